// [hw/acr_pkg.sv]
// Purpose: Shared constants and types for the amplifier control bank
// Assumes: 8-bit register bank behind a two-wire slave port
// Notes:   Reserved bits are masked on write and read back as zero
package acr_pkg;

    // ****************************************
    // Bus identity and register offsets
    // ****************************************
    localparam logic [6:0] DEV_ADDR   = 7'h44;
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_THR    = 4'h1;
    localparam logic [3:0] OFS_XPD    = 4'h2;
    localparam logic [3:0] OFS_AMP    = 4'h3;
    localparam logic [3:0] OFS_RXO    = 4'h7;
    localparam logic [3:0] OFS_LVL    = 4'hb;
    localparam logic [3:0] OFS_FMK    = 4'hc;
    localparam logic [3:0] OFS_RMK    = 4'hd;
    localparam logic [3:0] OFS_STAT   = 4'hf;
    localparam int         NUM_REGS   = 16;
    localparam logic [7:0] RESET_VAL  = 8'h00;

    // ****************************************
    // Writable-bit masks
    // ****************************************
    localparam logic [7:0] MSK_CTRL   = 8'h3e;
    localparam logic [7:0] MSK_FULL   = 8'hff;
    localparam logic [7:0] MSK_XPD    = 8'h3f;
    localparam logic [7:0] MSK_AMP    = 8'h07;
    localparam logic [7:0] MSK_RXO    = 8'h8d;
    localparam logic [7:0] MSK_STAT   = 8'h7f;
    localparam logic [7:0] MSK_NONE   = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_CLK_GATE = 5;
    localparam int BIT_INVERT   = 4;
    localparam int BIT_OFF      = 3;
    localparam int BIT_RANGE    = 2;
    localparam int BIT_OC_OFF   = 1;
    localparam int BIT_FLAG     = 7;
    localparam int BIT_BIAS     = 0;
    localparam int XP_LSB       = 4;
    localparam int DE_LSB       = 0;
    localparam int RXT_LSB      = 2;
    localparam int CODE7_LSB    = 0;
    localparam logic [7:0] THR_ZERO = 8'h80;

    function automatic logic [7:0] acr_wmask(input logic [3:0] idx);
        case (idx)
            OFS_CTRL: acr_wmask = MSK_CTRL;
            OFS_THR:  acr_wmask = MSK_FULL;
            OFS_XPD:  acr_wmask = MSK_XPD;
            OFS_AMP:  acr_wmask = MSK_AMP;
            OFS_RXO:  acr_wmask = MSK_RXO;
            OFS_LVL:  acr_wmask = MSK_FULL;
            OFS_FMK:  acr_wmask = MSK_FULL;
            OFS_RMK:  acr_wmask = MSK_FULL;
            default:  acr_wmask = MSK_NONE;
        endcase
    endfunction

    typedef enum logic [9:0] {
        ST_IDLE  = 10'b00_0000_0001,
        ST_ADDR  = 10'b00_0000_0010,
        ST_AACK  = 10'b00_0000_0100,
        ST_REG   = 10'b00_0000_1000,
        ST_RACK  = 10'b00_0001_0000,
        ST_WDATA = 10'b00_0010_0000,
        ST_WACK  = 10'b00_0100_0000,
        ST_RDATA = 10'b00_1000_0000,
        ST_MACK  = 10'b01_0000_0000,
        ST_HOLD  = 10'b10_0000_0000
    } acr_state_e;

    typedef struct packed {
        logic       serial_clock_gate;
        logic       output_invert;
        logic       output_off;
        logic       loss_range_high;
        logic       offset_cancel_off;
        logic [7:0] threshold_code;
        logic [1:0] crosspoint_range;
        logic [3:0] deemphasis_code;
        logic [2:0] swing_code;
        logic       rx_tuning_sel;
        logic [1:0] rx_tuning_code;
        logic       input_bias_boost;
        logic       assert_level_source;
        logic [6:0] assert_level_code;
        logic       fall_mask_enable;
        logic [6:0] fall_mask_time;
        logic       rise_mask_enable;
        logic [6:0] rise_mask_time;
    } acr_cfg_s;

    typedef struct packed {
        logic       adjust_off;
        logic       shift_pos;
        logic       shift_neg;
        logic       zero_powered;
        logic [6:0] magnitude;
    } acr_thr_s;

endpackage

// [hw/acr_pin_edge.sv]
// Purpose: Registers a bus pin and flags its edges
// Assumes: Pin is synchronous to clk
// Notes:   Idles high, like an undriven two-wire line
`timescale 1ns/1ns
module acr_pin_edge (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic prev;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level <= 1'b1;
            prev  <= 1'b1;
        end else begin
            level <= pin;
            prev  <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule // acr_pin_edge

// [hw/acr_thr_dec.sv]
// Purpose: Decodes the input threshold code into shift controls
// Assumes: Purely combinational, registered by the caller
// Notes:   Magnitude 127 is the largest shift either way
`timescale 1ns/1ns
module acr_thr_dec (
    input  wire logic [7:0]       code,
    output acr_pkg::acr_thr_s     thr
);
    always_comb begin
        thr = '0;
        if (code == 8'h00) begin
            thr.adjust_off = 1'b1;                        // RL7
        end else if (code < acr_pkg::THR_ZERO) begin
            thr.shift_pos = 1'b1;                         // RL8
            thr.magnitude = 7'(acr_pkg::THR_ZERO - code); // RL8
        end else if (code == acr_pkg::THR_ZERO) begin
            thr.zero_powered = 1'b1;                      // RL9
        end else begin
            thr.shift_neg = 1'b1;                         // RL10
            thr.magnitude = 7'(code - acr_pkg::THR_ZERO); // RL10
        end
    end

endmodule // acr_thr_dec

// [hw/acr_amp_ctl.sv]
// Purpose: Two-wire slave port and control register bank
// Assumes: Pins synchronous to clk; clk far faster than serial clock
// Notes:   One data byte per transfer; extra bytes are not acknowledged
//
// Overview of operation
// RL1 - Clock-gate bit set and disable pin high: serial clock ignored.
// RL2 - Control bit 4 set inverts data output polarity.
// RL3 - Control bit 2 selects high or low loss assert range.
// RL4 - Control bit 1 set turns off input offset cancellation.
// RL5 - Control register layout: bits 5..1 used, bits 7, 6, 0 unused.
// RL6 - Threshold register holds a full 8-bit adjust code.
// RL7 - Threshold code zero switches the adjust circuit off.
// RL8 - Codes 1 to 127 shift positive, largest at code 1.
// RL9 - Code 128 gives zero shift with the circuit still powered.
// RL10 - Codes 129 to 255 shift negative, largest at code 255.
// RL11 - Register 2: crosspoint range bits 5:4, de-emphasis bits 3:0.
// RL12 - Register 3: 3-bit swing code in bits 2:0.
// RL13 - Register 7: select bit 7, tuning bits 3:2, bias bit 0.
// RL14 - Register 11: source select bit 7, assert level bits 6:0.
// RL15 - Register 12: fall mask enable bit 7, time bits 6:0.
// RL16 - Register 13: rise mask enable bit 7, time bits 6:0.
// RL17 - Register 15 reports 7-bit loss level, bit 7 zero.
// RL18 - Slave address 1000100; direction bit zero writes, one reads.
// RL19 - Registers 0 to 13 read and write; register 15 read only. Here registers 4 to 6 and 8 to 10 ignore writes and read zero.
// RL20 - Exactly one data byte moves between start and stop.
// RL21 - Unused bits ignore writes and read back zero.
`timescale 1ns/1ns
module acr_amp_ctl (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        scl,
    input  wire logic        sda_in,
    input  wire logic        output_off_pin,
    input  wire logic [6:0]  loss_level_in,
    output logic             sda_out,
    output logic             sda_oe,
    output acr_pkg::acr_cfg_s cfg,
    output acr_pkg::acr_thr_s thr
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_q0;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q0     <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_q0     <= 1'b1;
            rst_sync_b <= rst_q0;
        end
    end

    // ****************************************
    // Pin edges and bus conditions
    // ****************************************
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;

    acr_pin_edge u_scl_edge (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .pin   (scl),
        .level (scl_lvl),
        .rise  (scl_rise),
        .fall  (scl_fall)
    );

    acr_pin_edge u_sda_edge (
        .clk   (clk),
        .rst_b (rst_sync_b),
        .pin   (sda_in),
        .level (sda_lvl),
        .rise  (sda_rise),
        .fall  (sda_fall)
    );

    logic [7:0] regs [acr_pkg::NUM_REGS];
    logic       gate;
    logic       rise_g;
    logic       fall_g;
    logic       start_det;
    logic       stop_det;

    // Gating freezes the port; edges and conditions are all dropped
    assign gate      = regs[acr_pkg::OFS_CTRL][acr_pkg::BIT_CLK_GATE]
                       & output_off_pin;             // RL1
    assign rise_g    = scl_rise & ~gate;             // RL1
    assign fall_g    = scl_fall & ~gate;             // RL1
    assign start_det = sda_fall & scl_lvl & ~gate;
    assign stop_det  = sda_rise & scl_lvl & ~gate;

    // ****************************************
    // Protocol state
    // ****************************************
    acr_pkg::acr_state_e state;
    acr_pkg::acr_state_e next_state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic       rw;
    logic       byte_full;
    logic       addr_hit;
    logic       wr_en;
    logic       rx_state;
    logic [7:0] rd_byte;

    assign byte_full = (bitcnt == 4'd8);
    assign addr_hit  = (shreg[7:1] == acr_pkg::DEV_ADDR);   // RL18
    assign rx_state  = (state == acr_pkg::ST_ADDR)
                     | (state == acr_pkg::ST_REG)
                     | (state == acr_pkg::ST_WDATA);
    assign wr_en     = (state == acr_pkg::ST_WDATA)
                     & fall_g & byte_full;           // RL20

    always_comb begin
        next_state = state;
        if (stop_det) begin
            next_state = acr_pkg::ST_IDLE;
        end else if (start_det) begin
            next_state = acr_pkg::ST_ADDR;
        end else if (fall_g) begin
            case (state)
                acr_pkg::ST_ADDR: begin
                    if (byte_full) begin
                        next_state = addr_hit ? acr_pkg::ST_AACK
                                              : acr_pkg::ST_HOLD;
                    end
                end
                acr_pkg::ST_AACK: begin
                    next_state = rw ? acr_pkg::ST_RDATA
                                    : acr_pkg::ST_REG;  // RL18
                end
                acr_pkg::ST_REG: begin
                    if (byte_full) begin
                        next_state = acr_pkg::ST_RACK;
                    end
                end
                acr_pkg::ST_RACK: begin
                    next_state = acr_pkg::ST_WDATA;
                end
                acr_pkg::ST_WDATA: begin
                    if (byte_full) begin
                        next_state = acr_pkg::ST_WACK;
                    end
                end
                acr_pkg::ST_WACK: begin
                    next_state = acr_pkg::ST_HOLD;     // RL20
                end
                acr_pkg::ST_RDATA: begin
                    if (bitcnt == 4'd7) begin
                        next_state = acr_pkg::ST_MACK;
                    end
                end
                acr_pkg::ST_MACK: begin
                    next_state = acr_pkg::ST_HOLD;     // RL20
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= acr_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Bits are sampled on the rise, counter cleared on every move
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bitcnt <= 4'h0;
            shreg  <= 8'h00;
        end else if (next_state != state) begin
            bitcnt <= 4'h0;
        end else if (rise_g && rx_state && !byte_full) begin
            bitcnt <= bitcnt + 4'h1;
            shreg  <= {shreg[6:0], sda_lvl};
        end else if (fall_g && state == acr_pkg::ST_RDATA) begin
            bitcnt <= bitcnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rw  <= 1'b0;
            ptr <= 8'h00;
        end else begin
            if (state == acr_pkg::ST_ADDR && next_state ==
                acr_pkg::ST_AACK) begin
                rw <= shreg[0];                          // RL18
            end
            if (state == acr_pkg::ST_REG && next_state ==
                acr_pkg::ST_RACK) begin
                ptr <= shreg;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Addresses above 15 and holes in the map read as zero
    always_comb begin
        rd_byte = 8'h00;
        if (ptr[7:4] != 4'h0) begin
            rd_byte = 8'h00;
        end else if (ptr[3:0] == acr_pkg::OFS_STAT) begin
            rd_byte = {1'b0, loss_level_in};             // RL17
        end else begin
            rd_byte = regs[ptr[3:0]];                    // RL19
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            tx <= 8'h00;
        end else if (state == acr_pkg::ST_AACK && fall_g && rw) begin
            tx <= rd_byte;
        end else if (state == acr_pkg::ST_RDATA && fall_g) begin
            tx <= {tx[6:0], 1'b0};
        end
    end

    // Open drain: only ever pull low, release for a one
    always_comb begin
        case (state)
            acr_pkg::ST_AACK:  sda_oe = 1'b1;
            acr_pkg::ST_RACK:  sda_oe = 1'b1;
            acr_pkg::ST_WACK:  sda_oe = 1'b1;
            acr_pkg::ST_RDATA: sda_oe = ~tx[7];
            default:           sda_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ****************************************
    // Register bank
    // ****************************************
    // Status slot and map holes have an empty mask, so stay zero
    for (genvar i = 0; i < acr_pkg::NUM_REGS; i++) begin : g_reg
        always_ff @(posedge clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
                regs[i] <= acr_pkg::RESET_VAL;
            end else if (wr_en && ptr == 8'(i)) begin
                regs[i] <= shreg & acr_pkg::acr_wmask(4'(i)); // RL21
            end
        end
    end

    // ****************************************
    // Configuration fields
    // ****************************************
    always_comb begin
        cfg = '0;
        cfg.serial_clock_gate   =
            regs[acr_pkg::OFS_CTRL][acr_pkg::BIT_CLK_GATE];    // RL5
        cfg.output_invert       =
            regs[acr_pkg::OFS_CTRL][acr_pkg::BIT_INVERT];      // RL2
        cfg.output_off          =
            regs[acr_pkg::OFS_CTRL][acr_pkg::BIT_OFF];         // RL5
        cfg.loss_range_high     =
            regs[acr_pkg::OFS_CTRL][acr_pkg::BIT_RANGE];       // RL3
        cfg.offset_cancel_off   =
            regs[acr_pkg::OFS_CTRL][acr_pkg::BIT_OC_OFF];      // RL4
        cfg.threshold_code      = regs[acr_pkg::OFS_THR];      // RL6
        cfg.crosspoint_range    =
            regs[acr_pkg::OFS_XPD][acr_pkg::XP_LSB +: 2];      // RL11
        cfg.deemphasis_code     =
            regs[acr_pkg::OFS_XPD][acr_pkg::DE_LSB +: 4];      // RL11
        cfg.swing_code          = regs[acr_pkg::OFS_AMP][2:0]; // RL12
        cfg.rx_tuning_sel       =
            regs[acr_pkg::OFS_RXO][acr_pkg::BIT_FLAG];         // RL13
        cfg.rx_tuning_code      =
            regs[acr_pkg::OFS_RXO][acr_pkg::RXT_LSB +: 2];     // RL13
        cfg.input_bias_boost    =
            regs[acr_pkg::OFS_RXO][acr_pkg::BIT_BIAS];         // RL13
        cfg.assert_level_source =
            regs[acr_pkg::OFS_LVL][acr_pkg::BIT_FLAG];         // RL14
        cfg.assert_level_code   =
            regs[acr_pkg::OFS_LVL][acr_pkg::CODE7_LSB +: 7];   // RL14
        cfg.fall_mask_enable    =
            regs[acr_pkg::OFS_FMK][acr_pkg::BIT_FLAG];         // RL15
        cfg.fall_mask_time      =
            regs[acr_pkg::OFS_FMK][acr_pkg::CODE7_LSB +: 7];   // RL15
        cfg.rise_mask_enable    =
            regs[acr_pkg::OFS_RMK][acr_pkg::BIT_FLAG];         // RL16
        cfg.rise_mask_time      =
            regs[acr_pkg::OFS_RMK][acr_pkg::CODE7_LSB +: 7];   // RL16
    end

    // ****************************************
    // Threshold decode
    // ****************************************
    acr_pkg::acr_thr_s next_thr;

    acr_thr_dec u_thr_dec (
        .code (regs[acr_pkg::OFS_THR]),
        .thr  (next_thr)
    );

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            thr <= '0;
        end else begin
            thr <= next_thr;                                   // RL7
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_b);

    sequence s_ctrl_wr;
        wr_en && ptr == 8'(acr_pkg::OFS_CTRL);
    endsequence

    sequence s_addr_done;
        state == acr_pkg::ST_ADDR && fall_g && byte_full
            && !start_det && !stop_det;
    endsequence

    sequence s_load_status;
        state == acr_pkg::ST_AACK && fall_g && rw
            && ptr == 8'(acr_pkg::OFS_STAT);
    endsequence

    AST_GATE_FREEZE: assert property ( // RL1
        gate |=> state == $past(state))
        else $error("port moved while serial clock gated");

    AST_INVERT_WR: assert property ( // RL2
        s_ctrl_wr |=> cfg.output_invert == $past(shreg[4]))
        else $error("polarity bit not taken from write");

    AST_RANGE_OC_WR: assert property ( // RL3
        s_ctrl_wr |=> cfg.loss_range_high == $past(shreg[2])
            && cfg.offset_cancel_off == $past(shreg[1]))
        else $error("range or offset bit not taken");

    AST_THR_FULL: assert property ( // RL6
        wr_en && ptr == 8'(acr_pkg::OFS_THR)
            |=> cfg.threshold_code == $past(shreg))
        else $error("threshold code not stored whole");

    AST_THR_DECODE: assert property ( // RL8
        cfg.threshold_code inside {[8'h01:8'h7f]}
            && $stable(cfg.threshold_code)
            |=> thr.shift_pos && !thr.shift_neg
            && thr.magnitude == 7'(8'h80 - $past(cfg.threshold_code)))
        else $error("positive threshold decode wrong");

    AST_THR_ENDS: assert property ( // RL9
        $stable(cfg.threshold_code) |=>
            (thr.adjust_off == ($past(cfg.threshold_code) == 8'h00))
            && (thr.zero_powered == ($past(cfg.threshold_code) == 8'h80))
            && (thr.shift_neg == ($past(cfg.threshold_code) > 8'h80)))
        else $error("threshold off, zero or negative decode wrong");

    AST_ADDR_ACK: assert property ( // RL18
        s_addr_done |=> (sda_oe == $past(addr_hit))
            && (state == acr_pkg::ST_AACK) == $past(addr_hit))
        else $error("address acknowledge wrong");

    AST_STATUS_READ: assert property ( // RL19
        s_load_status |=> tx == {1'b0, $past(loss_level_in)})
        else $error("status register not read from input");

    AST_ONE_BYTE: assert property ( // RL20
        state == acr_pkg::ST_WACK && fall_g && !stop_det
            && !start_det |=> state == acr_pkg::ST_HOLD ##1 !sda_oe)
        else $error("second data byte acknowledged");

    AST_RSV_ZERO: assert property ( // RL21
        ptr[7:4] == 4'h0 && ptr[3:0] != acr_pkg::OFS_STAT
            |-> (rd_byte & ~acr_pkg::acr_wmask(ptr[3:0])) == 8'h00)
        else $error("reserved bit reads as one");

endmodule // acr_amp_ctl

// [test/acr_master_model.sv]
// Purpose: Two-wire bus master model driving the control bank
// Assumes: Data line idles high through a pull-up
// Notes:   Half phase of 10 clk keeps scl low and high above 8 clk
`timescale 1ns/1ns
module acr_master_model (
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    // ****************************************
    // Bus phases
    // ****************************************
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hw();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        sda_drv = 1'b0;
        hw();
        scl = 1'b0;
        hw();
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        hw();
        scl = 1'b1;
        hw();
        sda_drv = 1'b1;
        hw();
    endtask
    // Data moves only while scl is low
    task automatic bitx(input logic b, output logic s);
        sda_drv = b;
        hw();
        scl = 1'b1;
        hw();
        s = sda_wire;
        hw();
        scl = 1'b0;
        hw();
    endtask
    // MSB first, ninth slot returns the acknowledge
    task automatic byt(input logic [7:0] d, output logic [7:0] q,
                       output logic a);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, s);
        a = ~s;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] r, d,
                      input logic x, output logic [3:0] ak);
        logic [7:0] q;
        start();
        byt({a, 1'b0}, q, ak[3]);
        byt(r, q, ak[2]);
        byt(d, q, ak[1]);
        ak[0] = 1'b0;
        if (x) byt(d, q, ak[0]);
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] r,
                      output logic [7:0] d, output logic [2:0] ak);
        logic [7:0] q;
        logic       s;
        start();
        byt({a, 1'b0}, q, ak[2]);
        byt(r, q, ak[1]);
        start();
        byt({a, 1'b1}, q, ak[0]);
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(1'b1, s);
        stop();
    endtask
endmodule // acr_master_model

// [test/tb.sv]
// Purpose: Self-checking bench for the amplifier control bank
// Assumes: Master model owns scl and its share of the data line
// Notes:   Read data is judged against masks worked out by hand
`timescale 1ns/1ns
module tb;
    logic              clk, rst_b, pin, sda_w, sda_out, sda_oe, scl, sda_drv;
    logic [6:0]        lvl;
    logic [3:0]        ak;
    logic [7:0]        q;
    acr_pkg::acr_cfg_s cfg;
    acr_pkg::acr_thr_s thr;
    int                errors, n_compared;
    assign sda_w = sda_drv & (~sda_oe | sda_out);
    acr_amp_ctl acr_amp_ctl_inst (.clk(clk), .rst_b(rst_b), .scl(scl),
        .sda_in(sda_w), .output_off_pin(pin), .loss_level_in(lvl),
        .sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg), .thr(thr));
    acr_master_model acr_master_model_inst (.clk(clk), .sda_wire(sda_w),
        .scl(scl), .sda_drv(sda_drv));
    always #2 clk = ~clk;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [15:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] r, d);
        acr_master_model_inst.wr(acr_pkg::DEV_ADDR, r, d, 1'b0, ak);
        chk(16'(ak), 16'h000e);
    endtask
    task automatic rd(input logic [7:0] r);
        acr_master_model_inst.rd(acr_pkg::DEV_ADDR, r, q, ak[2:0]);
        chk(16'(ak[2:0]), 16'h0007);
    endtask
    task automatic give_verdict();
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [7:0] ofs [8] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h7, 8'hb,
                                8'hc, 8'hd};
        logic [7:0] msk [8] = '{8'h3e, 8'hff, 8'h3f, 8'h07, 8'h8d, 8'hff,
                                8'hff, 8'hff};
        rd(8'h00);
        chk(16'(q), 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(ofs[i], 8'hff);
            rd(ofs[i]);
            chk(16'(q), 16'(msk[i]));
        end
        chk(16'(cfg.output_invert), 16'h0001);
        chk(16'(cfg.loss_range_high), 16'h0001);
        chk(16'(cfg.offset_cancel_off), 16'h0001);
        chk(16'(cfg.fall_mask_time), 16'h007f);
        chk(16'(cfg.rise_mask_enable), 16'h0001);
        // Every mapped field was written all ones, so the whole struct is
        chk(16'(&cfg), 16'h0001);
        wr(8'h00, 8'hc1);
        rd(8'h00);
        chk(16'(q), 16'h0000);
    endtask
    task automatic t_status();
        acr_master_model_inst.wr(acr_pkg::DEV_ADDR, 8'h0f, 8'hff, 1'b0, ak);
        rd(8'h0f);
        chk(16'(q), 16'h005a);
        chk(16'(sda_out), 16'h0000);
        rd(8'h05);
        chk(16'(q), 16'h0000);
    endtask
    task automatic t_bus();
        acr_master_model_inst.wr(7'h45, 8'h01, 8'h00, 1'b0, ak);
        chk(16'(ak), 16'h0000);
        rd(8'h01);
        chk(16'(q), 16'h00ff);
        acr_master_model_inst.wr(acr_pkg::DEV_ADDR, 8'h03, 8'h05, 1'b1, ak);
        chk(16'(ak), 16'h000e);
        rd(8'h03);
        chk(16'(q), 16'h0005);
    endtask
    task automatic t_thr();
        logic [7:0]        c [6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};
        acr_pkg::acr_thr_s e;
        for (int i = 0; i < 6; i++) begin
            wr(8'h01, c[i]);
            e.adjust_off = (c[i] == 8'h00);
            e.shift_pos = (c[i] != 8'h00) && !c[i][7];
            e.shift_neg = c[i] > 8'h80;
            e.zero_powered = (c[i] == 8'h80);
            e.magnitude = c[i][7] ? c[i][6:0] : 7'(8'h80 - c[i]);
            chk(16'(thr), 16'(e));
        end
    endtask
    task automatic t_gate();
        wr(8'h00, 8'h20);
        pin = 1'b1;
        acr_master_model_inst.wr(acr_pkg::DEV_ADDR, 8'h01, 8'h33, 1'b0, ak);
        chk(16'(ak), 16'h0000);
        pin = 1'b0;
        rd(8'h01);
        chk(16'(q), 16'h00ff);
        wr(8'h00, 8'h00);
        pin = 1'b1;
        wr(8'h01, 8'h66);
        rd(8'h01);
        chk(16'(q), 16'h0066);
        pin = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        pin = 1'b0;
        lvl = 7'h5a;
        errors = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk(16'(cfg.swing_code), 16'h0000);
        t_regs();
        t_status();
        t_bus();
        t_thr();
        t_gate();
        give_verdict();
    end
    // Guards against a hung bus sequence
    initial begin
        repeat (95000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule // tb
